//--- shared/dmo_pkg.sv
// Constants, field layouts and carrier types for the display memory organizer.
// Assumes a single 25 MHz core clock and register offsets taken from the chip register base.
// Functional notes
// R01 - Up to 4 MB aperture above installed RAM.
// R02 - Aperture start and size on 128 KB.
// R03 - Memory addressed by 20-bit DWORD offset plus enables.
// R04 - Modes 640/800/1024 at 8/16, 1280 at 8.
// R05 - Pixel offset is Y concatenated with X.
// R06 - 8 BPP modes below 1280 use 1024-byte line delta.
// R07 - 16 BPP and 1280 use 2048-byte delta.
// R08 - Compressed line data fills gap after pixels.
// R09 - 1024x768 compressed buffer is linear after frame.
// R10 - VGA data lives in 256 KB region.
// R11 - Mode 13h and planar D-12 scan directly.
// R12 - Software converts text modes to 8 BPP.
// R13 - Cursor buffer 16-byte aligned, 256 bytes long.
// R14 - Cursor is 32x32 pixels of 2-bit codes.
// R15 - Two DWORDs per line, AND high, XOR low.
// R16 - Leftmost 16-pixel block in lower DWORD.
// R17 - Leftmost pixel in most significant bit.
// R18 - New cursor offset applies at next frame.
// R19 - Register block is 100h bytes at 8300h.
// R20 - Lock blocks writes to critical registers, reads allowed.
// R21 - Locked writes are dropped silently, no error.
package dmo_pkg;
	// Register offsets from the chip register base.
	localparam logic [15:0] OFS_WRITE_LOCK = 16'h8300;
	localparam logic [15:0] OFS_GENERAL_CFG = 16'h8304;
	localparam logic [15:0] OFS_TIMING_CFG = 16'h8308;
	localparam logic [15:0] OFS_OUTPUT_CFG = 16'h830C;
	localparam logic [15:0] OFS_FB_START = 16'h8310;
	localparam logic [15:0] OFS_CMP_START = 16'h8314;
	localparam logic [15:0] OFS_CURSOR_START = 16'h8318;
	// Window of the register block and its size in bytes.
	localparam logic [15:0] OFS_BLOCK_BASE = 16'h8300;
	localparam logic [15:0] BLOCK_BYTES = 16'h0100;
	// Values after reset.
	localparam logic [31:0] RST_WRITE_LOCK = 32'h00000000;
	localparam logic [31:0] RST_GENERAL_CFG = 32'h00000000;
	localparam logic [31:0] RST_OTHER = 32'h00000000;
	// Field positions inside the general configuration register.
	localparam int RES_LSB = 0;
	localparam int BPP16_BIT = 2;
	// Resolution codes.
	localparam logic [1:0] RES_640 = 2'h0;
	localparam logic [1:0] RES_800 = 2'h1;
	localparam logic [1:0] RES_1024 = 2'h2;
	localparam logic [1:0] RES_1280 = 2'h3;
	// Line deltas as DWORD shift counts: 1024 bytes and 2048 bytes.
	localparam int SHIFT_DELTA_1K = 8;
	localparam int SHIFT_DELTA_2K = 9;
	// Aperture granule of 128 KB is address bit 17; 4 MB is 32 granules.
	localparam int GRANULE_LSB = 17;
	localparam logic [5:0] MAX_GRANULES = 6'h20;
	// VGA region of 256 KB is 65536 DWORDs.
	localparam int VGA_DWORD_BITS = 16;
	// Cursor buffer alignment of 16 bytes is two DWORD offset bits.
	localparam int CURSOR_ALIGN_BITS = 2;
	// Display mode carried from the configuration register.
	typedef struct packed {
		logic bpp16;
		logic [1:0] res;
	} dmo_mode_t;
	// One graphics memory access: DWORD offset and byte enables.
	typedef struct packed {
		logic [19:0] dwOffset;
		logic [3:0] byteEn;
	} dmo_mem_t;
endpackage : dmo_pkg

//--- logic/dmo_top.sv
// Display memory organizer: register block, aperture decode, frame, compression, VGA and cursor addressing.
// Assumes all requests arrive synchronous to clk from on-chip logic; the register port is the memory-mapped
// window at the chip register base, offsets given relative to that base.
`timescale 1ns/1ps
module dmo_top #(
	parameter logic [31:0] UNLOCK_KEY = 32'h00005A3C, // Arbitrary key value that opens the lock.
	parameter int CMP_LINE_SHIFT = 6 // DWORD shift of one linear compressed line (256 bytes).
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [3:0] regByteEn,
	input wire logic [31:0] regWrData,
	output logic [31:0] regRdData,
	output logic regRdValid,
	input wire logic [14:0] apertureBase,
	input wire logic [5:0] apertureGranules,
	input wire logic sysReq,
	input wire logic [31:0] sysAddr,
	input wire logic [3:0] sysByteEn,
	output logic apertureHit,
	output dmo_pkg::dmo_mem_t apertureMem,
	input wire logic pixReq,
	input wire logic [10:0] pixX,
	input wire logic [10:0] pixY,
	output logic pixValid,
	output logic [19:0] pixDwOffset,
	output logic [19:0] cmpDwOffset,
	output logic modeBad,
	input wire logic [15:0] vgaDwIndex,
	input wire logic [7:0] vgaMode,
	input wire logic [19:0] vgaBase,
	output logic [19:0] vgaDwOffset,
	output logic vgaDirect,
	input wire logic frameStart,
	input wire logic [4:0] cursorLine,
	input wire logic cursorHalf,
	input wire logic [31:0] cursorLeftDw,
	input wire logic [31:0] cursorRightDw,
	input wire logic [4:0] cursorPixX,
	output logic [19:0] cursorDwOffset,
	output logic cursorAnd,
	output logic cursorXor
);

	// Register storage.
	logic [31:0] lockQ, lockD; // Lock key register.
	logic [31:0] genQ, genD; // General configuration.
	logic [31:0] timQ, timD; // Timing configuration.
	logic [31:0] outQ, outD; // Output configuration.
	logic [31:0] fbQ, fbD; // Frame buffer start.
	logic [31:0] cmpQ, cmpD; // Compression buffer start.
	logic [31:0] curQ, curD; // Cursor start as last written.
	logic [19:0] curActQ, curActD; // Cursor start in use for this frame.
	logic [31:0] rdQ, rdD; // Read data.
	logic rdValQ, rdValD; // Read answer strobe.
	logic unlocked; // Lock open.
	logic inBlock; // Address inside the register block.
	dmo_pkg::dmo_mode_t mode; // Current display mode.

	// Byte-enable merge of a write onto a stored word.
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : mergeBytes

	assign mode = '{bpp16: genQ[dmo_pkg::BPP16_BIT], res: genQ[dmo_pkg::RES_LSB +: 2]};
	// R20 lock state
	assign unlocked = (lockQ == UNLOCK_KEY);
	// R19 block window
	assign inBlock = (regAddr >= dmo_pkg::OFS_BLOCK_BASE) &&
		(regAddr < dmo_pkg::OFS_BLOCK_BASE + dmo_pkg::BLOCK_BYTES);

	// Register writes, reads and the cursor start latch.
	always_comb begin
		lockD = lockQ;
		genD = genQ;
		timD = timQ;
		outD = outQ;
		fbD = fbQ;
		cmpD = cmpQ;
		curD = curQ;
		curActD = curActQ;
		rdD = rdQ;
		rdValD = 1'b0;
		// R20 protected writes
		// R21 silent discard
		if (regWrite && regAddr == dmo_pkg::OFS_WRITE_LOCK) begin
			// The lock register itself is always writable, or software could never open it.
			lockD = mergeBytes(lockQ, regWrData, regByteEn);
		end else if (regWrite && unlocked) begin
			if (regAddr == dmo_pkg::OFS_GENERAL_CFG) begin
				genD = mergeBytes(genQ, regWrData, regByteEn);
			end else if (regAddr == dmo_pkg::OFS_TIMING_CFG) begin
				timD = mergeBytes(timQ, regWrData, regByteEn);
			end else if (regAddr == dmo_pkg::OFS_OUTPUT_CFG) begin
				outD = mergeBytes(outQ, regWrData, regByteEn);
			end else if (regAddr == dmo_pkg::OFS_FB_START) begin
				fbD = mergeBytes(fbQ, regWrData, regByteEn);
			end else if (regAddr == dmo_pkg::OFS_CMP_START) begin
				cmpD = mergeBytes(cmpQ, regWrData, regByteEn);
			end else if (regAddr == dmo_pkg::OFS_CURSOR_START) begin
				curD = mergeBytes(curQ, regWrData, regByteEn);
			end
		end
		// R18 next frame
		if (frameStart) begin
			// Low offset bits are forced to zero, keeping the 16-byte alignment software promised.
			curActD = {curQ[21:4], 2'h0};
		end
		// R20 reads always allowed
		if (regRead && inBlock) begin
			rdValD = 1'b1;
			if (regAddr == dmo_pkg::OFS_WRITE_LOCK) begin
				rdD = lockQ;
			end else if (regAddr == dmo_pkg::OFS_GENERAL_CFG) begin
				rdD = genQ;
			end else if (regAddr == dmo_pkg::OFS_TIMING_CFG) begin
				rdD = timQ;
			end else if (regAddr == dmo_pkg::OFS_OUTPUT_CFG) begin
				rdD = outQ;
			end else if (regAddr == dmo_pkg::OFS_FB_START) begin
				rdD = fbQ;
			end else if (regAddr == dmo_pkg::OFS_CMP_START) begin
				rdD = cmpQ;
			end else if (regAddr == dmo_pkg::OFS_CURSOR_START) begin
				rdD = curQ;
			end else begin
				// Unused locations inside the block read as zero.
				rdD = 32'h00000000;
			end
		end
	end

	// Register state flip-flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lockQ <= dmo_pkg::RST_WRITE_LOCK;
			genQ <= dmo_pkg::RST_GENERAL_CFG;
			timQ <= dmo_pkg::RST_OTHER;
			outQ <= dmo_pkg::RST_OTHER;
			fbQ <= dmo_pkg::RST_OTHER;
			cmpQ <= dmo_pkg::RST_OTHER;
			curQ <= dmo_pkg::RST_OTHER;
			curActQ <= 20'h00000;
			rdQ <= dmo_pkg::RST_OTHER;
			rdValQ <= 1'b0;
		end else begin
			lockQ <= lockD;
			genQ <= genD;
			timQ <= timD;
			outQ <= outD;
			fbQ <= fbD;
			cmpQ <= cmpD;
			curQ <= curD;
			curActQ <= curActD;
			rdQ <= rdD;
			rdValQ <= rdValD;
		end
	end
	assign regRdData = rdQ;
	assign regRdValid = rdValQ;

	// Address pipeline registers.
	logic hitQ, hitD;
	dmo_pkg::dmo_mem_t apMemQ, apMemD;
	logic pixValQ, pixValD;
	logic [19:0] pixOffQ, pixOffD, cmpOffQ, cmpOffD, vgaOffQ, vgaOffD, curOffQ, curOffD;
	logic badQ, badD, vgaDirQ, vgaDirD, andQ, andD, xorQ, xorD;
	// Combinational helpers.
	logic [31:0] apLimit; // First byte above the aperture.
	logic [31:0] apRel; // Byte offset into the aperture.
	logic wide; // Line delta is 2048 bytes.
	logic [19:0] lineOff; // Y part of the DWORD offset.
	logic [19:0] xDw; // X part of the DWORD offset.
	logic [19:0] lineDw; // Pixel bytes per line in DWORDs.
	logic [31:0] curDw; // Cursor DWORD holding the pixel.
	logic [3:0] bitIdx; // Bit of the pixel inside a halfword.

	// Aperture decode, frame, compression, VGA and cursor addressing.
	always_comb begin
		// R01 aperture limit
		// R02 granule window
		apLimit = {apertureBase, 17'h00000} +
			{9'h000, ((apertureGranules > dmo_pkg::MAX_GRANULES) ? dmo_pkg::MAX_GRANULES : apertureGranules),
			17'h00000};
		apRel = sysAddr - {apertureBase, 17'h00000};
		hitD = sysReq && (sysAddr >= {apertureBase, 17'h00000}) && (sysAddr < apLimit);
		// R03 dword offset
		apMemD = apMemQ;
		if (sysReq) begin
			apMemD = '{dwOffset: apRel[21:2], byteEn: sysByteEn};
		end
		// R06 short delta
		// R07 long delta
		wide = mode.bpp16 || (mode.res == dmo_pkg::RES_1280);
		// R05 concatenated address
		lineOff = wide ? {pixY[10:0], 9'h000} : {1'b0, pixY[10:0], 8'h00};
		xDw = mode.bpp16 ? {10'h000, pixX[10:1]} : {11'h000, pixX[10:2]};
		case (mode.res)
			dmo_pkg::RES_640: lineDw = mode.bpp16 ? 20'h00140 : 20'h000A0;
			dmo_pkg::RES_800: lineDw = mode.bpp16 ? 20'h00190 : 20'h000C8;
			dmo_pkg::RES_1024: lineDw = mode.bpp16 ? 20'h00200 : 20'h00100;
			default: lineDw = 20'h00140;
		endcase
		pixValD = pixReq;
		pixOffD = pixOffQ;
		cmpOffD = cmpOffQ;
		if (pixReq) begin
			pixOffD = fbQ[21:2] + (lineOff | xDw);
			// R09 linear compression
			// R08 gap after line
			if (mode.res == dmo_pkg::RES_1024) begin
				cmpOffD = cmpQ[21:2] + 20'((32'(pixY) << CMP_LINE_SHIFT));
			end else begin
				cmpOffD = fbQ[21:2] + lineOff + lineDw;
			end
		end
		// R04 unsupported mode
		badD = mode.bpp16 && (mode.res == dmo_pkg::RES_1280);
		// R10 vga region
		vgaOffD = vgaBase + {4'h0, vgaDwIndex[dmo_pkg::VGA_DWORD_BITS-1:0]};
		// R11 direct scan
		// R12 text needs conversion
		case (vgaMode)
			8'h13, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12: vgaDirD = 1'b1;
			default: vgaDirD = 1'b0;
		endcase
		// R13 linear cursor
		// R15 two dwords
		curOffD = curActQ + {14'h0000, cursorLine, cursorHalf};
		// R16 left block low
		curDw = cursorPixX[4] ? cursorRightDw : cursorLeftDw;
		// R17 left pixel msb
		bitIdx = 4'hF - cursorPixX[3:0];
		// R14 and/xor code
		andD = curDw[16 + 32'(bitIdx)];
		xorD = curDw[bitIdx];
	end

	// Address pipeline flip-flops.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hitQ <= 1'b0;
			apMemQ <= '0;
			pixValQ <= 1'b0;
			pixOffQ <= 20'h00000;
			cmpOffQ <= 20'h00000;
			badQ <= 1'b0;
			vgaOffQ <= 20'h00000;
			vgaDirQ <= 1'b0;
			curOffQ <= 20'h00000;
			andQ <= 1'b0;
			xorQ <= 1'b0;
		end else begin
			hitQ <= hitD;
			apMemQ <= apMemD;
			pixValQ <= pixValD;
			pixOffQ <= pixOffD;
			cmpOffQ <= cmpOffD;
			badQ <= badD;
			vgaOffQ <= vgaOffD;
			vgaDirQ <= vgaDirD;
			curOffQ <= curOffD;
			andQ <= andD;
			xorQ <= xorD;
		end
	end
	assign apertureHit = hitQ;
	assign apertureMem = apMemQ;
	assign pixValid = pixValQ;
	assign pixDwOffset = pixOffQ;
	assign cmpDwOffset = cmpOffQ;
	assign modeBad = badQ;
	assign vgaDwOffset = vgaOffQ;
	assign vgaDirect = vgaDirQ;
	assign cursorDwOffset = curOffQ;
	assign cursorAnd = andQ;
	assign cursorXor = xorQ;

	// Checks kept beside the logic.
	sequence seqLockedWrite;
		regWrite && !unlocked && regAddr == dmo_pkg::OFS_FB_START;
	endsequence
	sequence seqCursorWrite;
		regWrite && unlocked && regAddr == dmo_pkg::OFS_CURSOR_START;
	endsequence
	AST_LOCK_DROP: assert property (@(posedge clk) disable iff (sys_rst) // R21
		seqLockedWrite |=> $stable(fbQ)) else $error("Locked write changed frame start.");
	AST_LOCK_OPEN: assert property (@(posedge clk) disable iff (sys_rst) // R20
		(regWrite && unlocked && regAddr == dmo_pkg::OFS_FB_START && regByteEn == 4'hF)
		|=> fbQ == $past(regWrData)) else $error("Unlocked write lost.");
	AST_READ_ALWAYS: assert property (@(posedge clk) disable iff (sys_rst) // R19
		(regRead && inBlock) |=> regRdValid) else $error("Read inside block not answered.");
	AST_CURSOR_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R18
		(seqCursorWrite ##1 !frameStart[*2]) |=> $stable(curActQ)) else $error("Cursor changed mid frame.");
	AST_CURSOR_TAKE: assert property (@(posedge clk) disable iff (sys_rst) // R13
		frameStart |=> curActQ[1:0] == 2'h0 && curActQ[19:2] == $past(curQ[21:4]))
		else $error("Cursor start not taken at frame.");
	AST_DELTA_WIDE: assert property (@(posedge clk) disable iff (sys_rst) // R07
		(pixReq && mode.bpp16 && pixX == 11'h000 && !$changed(fbQ))
		|=> pixDwOffset == $past(fbQ[21:2]) + {$past(pixY), 9'h000}) else $error("Wide delta wrong.");
	AST_DELTA_NARROW: assert property (@(posedge clk) disable iff (sys_rst) // R06
		(pixReq && !wide && pixX == 11'h000 && !$changed(fbQ))
		|=> pixDwOffset == $past(fbQ[21:2]) + {1'b0, $past(pixY), 8'h00}) else $error("Narrow delta wrong.");
	AST_APERTURE: assert property (@(posedge clk) disable iff (sys_rst) // R02
		(sysReq && sysAddr < {apertureBase, 17'h00000}) |=> !apertureHit) else $error("Hit below aperture.");
	AST_VGA_TEXT: assert property (@(posedge clk) disable iff (sys_rst) // R11
		(vgaMode == 8'h03) |=> !vgaDirect) else $error("Text mode scanned directly.");
	AST_PIX_VALID: assert property (@(posedge clk) disable iff (sys_rst) // R05
		pixReq |=> pixValid ##1 (pixValid == $past(pixReq))) else $error("Pixel answer timing wrong.");
endmodule : dmo_top

//--- test/dmo_cursor_mem.sv
// Behavioural model of the graphics memory that holds one cursor pattern buffer.
// Assumes the organizer presents a registered cursor DWORD offset and takes both line DWORDs back.
`timescale 1ns/1ps
module dmo_cursor_mem #(
	parameter logic [19:0] START_DW = 20'h00040 // Buffer start as a DWORD offset (byte 100h).
) (
	input wire logic clk,
	input wire logic [19:0] dwOffset,
	output logic [31:0] leftDw,
	output logic [31:0] rightDw
);
	// buffer 256 bytes: sixty-four DWORDs at a 16-byte aligned start.
	logic [31:0] mem [0:63];
	logic [19:0] rel;
	assign rel = dwOffset - START_DW;
	// Even words hold the left block, odd words the right block of a line.
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = i[0] ? 32'h00010002 : 32'h80014000;
		end
	end
	// Outside the buffer the data is not held, so the lines flip every cycle.
	always_ff @(posedge clk) begin
		if (rel < 20'h00040) begin
			leftDw <= mem[{rel[5:1], 1'b0}];
			rightDw <= mem[{rel[5:1], 1'b1}];
		end else begin
			leftDw <= ~leftDw;
			rightDw <= ~rightDw;
		end
	end
endmodule : dmo_cursor_mem

//--- test/tb_display_memory_organizer.sv
// Self-checking bench for the display memory organizer with a cursor memory model.
// Assumes the register window, aperture, pixel, VGA and cursor ports answer one cycle after a request.
`timescale 1ns/1ps
module tb_display_memory_organizer;
	localparam logic [31:0] KEY = 32'h00005A3C; // Arbitrary unlock key.
	logic clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, regRdValid, sysReq = 1'b0, apertureHit;
	logic [15:0] regAddr = 16'h0000, vgaDwIndex = 16'h0000;
	logic [3:0] regByteEn = 4'hF, sysByteEn = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, sysAddr = 32'h0, cursorLeftDw, cursorRightDw;
	logic [14:0] apertureBase = 15'h0040;
	logic [5:0] apertureGranules = 6'h02;
	dmo_pkg::dmo_mem_t apertureMem;
	logic pixReq = 1'b0, pixValid, modeBad, vgaDirect, frameStart = 1'b0, cursorHalf = 1'b0, cursorAnd, cursorXor;
	logic [10:0] pixX = 11'h0, pixY = 11'h0;
	logic [19:0] pixDwOffset, cmpDwOffset, vgaBase = 20'h10000, vgaDwOffset, cursorDwOffset;
	logic [7:0] vgaMode = 8'h00;
	logic [4:0] cursorLine = 5'h0, cursorPixX = 5'h0;
	int errors = 0, totalChecks = 0;
	dmo_top #(.UNLOCK_KEY(KEY), .CMP_LINE_SHIFT(6)) i_dmo_top (.clk, .sys_rst, .regWrite, .regRead, .regAddr,
		.regByteEn, .regWrData, .regRdData, .regRdValid, .apertureBase, .apertureGranules, .sysReq, .sysAddr,
		.sysByteEn, .apertureHit, .apertureMem, .pixReq, .pixX, .pixY, .pixValid, .pixDwOffset, .cmpDwOffset,
		.modeBad, .vgaDwIndex, .vgaMode, .vgaBase, .vgaDwOffset, .vgaDirect, .frameStart, .cursorLine,
		.cursorHalf, .cursorLeftDw, .cursorRightDw, .cursorPixX, .cursorDwOffset, .cursorAnd, .cursorXor);
	dmo_cursor_mem #(.START_DW(20'h00040)) i_dmo_cursor_mem (.clk(clk), .dwOffset(cursorDwOffset),
		.leftDw(cursorLeftDw), .rightDw(cursorRightDw));
	// Free-running core clock of 40 ns.
	initial begin
		forever #20 clk = ~clk;
	end
	// Inputs always move 1 ns after the rising edge.
	task step;
		@(posedge clk);
		#1;
	endtask : step
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task wr(input logic [15:0] a, input logic [31:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		step;
		regWrite = 1'b0;
		// One idle edge keeps the strobe from being lowered and raised in one time step.
		step;
	endtask : wr
	// Read with a bounded wait on the answer; a missing answer ends the run.
	task rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
		int n;
		regAddr = a;
		regRead = 1'b1;
		step;
		regRead = 1'b0;
		for (n = 0; n < 4; n++) begin
			if (regRdValid === 1'b1) break;
			step;
		end
		if (n == 4) begin
			errors++;
			$display("BAD %s expected answer seen none", nm);
			tally_and_finish;
		end
		chk(nm, exp, regRdData);
		step;
	endtask : rd
	task t_regs;
		rd(dmo_pkg::OFS_WRITE_LOCK, 32'h0, "lockReset");
		rd(dmo_pkg::OFS_GENERAL_CFG, 32'h0, "cfgReset");
		rd(16'h8340, 32'h0, "unusedRead");
		regAddr = 16'h8400;
		regRead = 1'b1;
		step;
		regRead = 1'b0;
		chk("outsideValid", 32'h0, {31'h0, regRdValid});
		$display("test regs done");
	endtask : t_regs
	// Locked writes vanish, the lock itself is always writable.
	task t_lock;
		wr(dmo_pkg::OFS_FB_START, 32'h00100000);
		rd(dmo_pkg::OFS_FB_START, 32'h0, "lockedFb");
		wr(dmo_pkg::OFS_WRITE_LOCK, KEY);
		rd(dmo_pkg::OFS_WRITE_LOCK, KEY, "lockOpen");
		wr(dmo_pkg::OFS_FB_START, 32'h00100000);
		rd(dmo_pkg::OFS_FB_START, 32'h00100000, "openFb");
		$display("test lock done");
	endtask : t_lock
	task pix(input logic [31:0] cfg, input logic [10:0] x, y, input logic [19:0] ep, ec, input logic eb);
		wr(dmo_pkg::OFS_GENERAL_CFG, cfg);
		pixX = x;
		pixY = y;
		pixReq = 1'b1;
		step;
		pixReq = 1'b0;
		chk("pixValid", 32'h1, {31'h0, pixValid});
		chk("pixOfs", {12'h0, ep}, {12'h0, pixDwOffset});
		chk("cmpOfs", {12'h0, ec}, {12'h0, cmpDwOffset});
		chk("modeBad", {31'h0, eb}, {31'h0, modeBad});
	endtask : pix
	// Frame base is DWORD 40000h, linear compressed buffer at DWORD 80000h.
	task t_pix;
		wr(dmo_pkg::OFS_CMP_START, 32'h00200000);
		pix(32'h0, 11'd8, 11'd1, 20'h40102, 20'h401A0, 1'b0);
		pix(32'h1, 11'd0, 11'd1, 20'h40100, 20'h401C8, 1'b0);
		pix(32'h4, 11'd8, 11'd1, 20'h40204, 20'h40340, 1'b0);
		pix(32'h2, 11'd1020, 11'd3, 20'h403FF, 20'h800C0, 1'b0);
		pix(32'h3, 11'd4, 11'd2, 20'h40401, 20'h40540, 1'b0);
		pix(32'h6, 11'd0, 11'd2, 20'h40400, 20'h80080, 1'b0);
		pix(32'h7, 11'd4, 11'd2, 20'h40402, 20'h40540, 1'b1);
		$display("test pixel done");
	endtask : t_pix
	task ap(input logic [31:0] a, input logic h, input logic [19:0] o);
		sysAddr = a;
		sysByteEn = 4'h3;
		sysReq = 1'b1;
		step;
		sysReq = 1'b0;
		chk("apHit", {31'h0, h}, {31'h0, apertureHit});
		if (h) chk("apMem", {8'h0, o, 4'h3}, {8'h0, apertureMem});
		step;
	endtask : ap
	// Aperture at 8 MB; first two granules, then a size clipped to 4 MB.
	task t_ap;
		ap(32'h00800010, 1'b1, 20'h00004);
		ap(32'h0083FFFC, 1'b1, 20'h0FFFF);
		ap(32'h00840000, 1'b0, 20'h0);
		ap(32'h007FFFFC, 1'b0, 20'h0);
		apertureGranules = 6'h28;
		ap(32'h00BFFFFC, 1'b1, 20'hFFFFF);
		ap(32'h00C00000, 1'b0, 20'h0);
		$display("test aperture done");
	endtask : t_ap
	task t_vga;
		vgaDwIndex = 16'hFFFF;
		for (int i = 0; i < 8; i++) begin
			vgaMode = 8'h0C + i[7:0];
			step;
			step;
			chk("vgaDirect", {31'h0, i != 0}, {31'h0, vgaDirect});
		end
		// Text mode 3 must never be scanned straight from the VGA buffer.
		vgaMode = 8'h03;
		step;
		step;
		chk("vgaText", 32'h0, {31'h0, vgaDirect});
		chk("vgaOfs", 32'h0001FFFF, {12'h0, vgaDwOffset});
		$display("test vga done");
	endtask : t_vga
	// The new start waits for a frame; then pixel bits follow the mask layout.
	task t_cur;
		static logic [4:0] xs [4] = '{5'd0, 5'd1, 5'd31, 5'd30};
		static logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h2, 2'h1};
		wr(dmo_pkg::OFS_CURSOR_START, 32'h00000100);
		cursorLine = 5'd1;
		cursorHalf = 1'b1;
		step;
		step;
		chk("curOld", 32'h3, {12'h0, cursorDwOffset});
		frameStart = 1'b1;
		step;
		frameStart = 1'b0;
		step;
		step;
		chk("curNew", 32'h43, {12'h0, cursorDwOffset});
		cursorLine = 5'd0;
		cursorHalf = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cursorPixX = xs[i];
			repeat (3) step;
			chk("curBits", {30'h0, ex[i]}, {30'h0, cursorAnd, cursorXor});
		end
		$display("test cursor done");
	endtask : t_cur
	// Main sequence: three reset cycles, then each scenario in turn.
	initial begin
		repeat (3) step;
		sys_rst = 1'b0;
		chk("rstOut", 32'h0, {29'h0, apertureHit, pixValid, regRdValid});
		t_regs;
		t_lock;
		t_pix;
		t_ap;
		t_vga;
		t_cur;
		tally_and_finish;
	end
endmodule : tb_display_memory_organizer
